// >>> verilog/epg_defines.vh
// Constants for the energy pulse generator
`ifndef EPG_DEFINES_VH
`define EPG_DEFINES_VH
`define EPG_CLK_HZ          100000000
`define EPG_TICK_HZ         4000
`define EPG_TICK_DIV        (`EPG_CLK_HZ / `EPG_TICK_HZ)
`define EPG_SAMPLE_HZ       4000
`define EPG_MWH_PER_KWH     64'd1000000
`define EPG_MS_PER_HOUR     64'd3600000
`define EPG_PULSES_DEFAULT  16'h1900
`define EPG_DUR_DEFAULT     8'h14
`define EPG_INT_THR_DEFAULT 32'h00030D40
`define EPG_HYST_MV         32'h000003E8
// Register word indices, byte address over four
`define EPG_REG_CTRL        4'h0
`define EPG_REG_PFLOOR      4'h1
`define EPG_REG_SFLOOR      4'h2
`define EPG_REG_INTTHR      4'h3
`define EPG_REG_PULSES      4'h4
`define EPG_REG_DUR         4'h5
`define EPG_REG_STATUS      4'h6
`define EPG_REG_MASK        4'h7
// Control fields
`define EPG_CTRL_RESET      32'h0000003F
`define EPG_C_PH_ACT        0
`define EPG_C_PH_REA        1
`define EPG_C_PH_APP        2
`define EPG_C_TOT_ACT       3
`define EPG_C_TOT_REA       4
`define EPG_C_TOT_APP       5
`define EPG_C_NEUTRAL       6
`define EPG_C_TWO_CH        7
// Status event bits
`define EPG_S_ACT_PULSE     0
`define EPG_S_REA_PULSE     1
`define EPG_S_INT_ENTER     2
`define EPG_S_INT_LEAVE     3
`define EPG_S_W             4
`endif

// >>> verilog/epg_top.v
// Energy pulse generator with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "epg_defines.vh"
module epg_top #(
  parameter NPH   = 3,
  parameter PW    = 32,
  parameter TICKD = `EPG_TICK_DIV
) (
  input  wire              clk,
  input  wire              sys_rst,
  // AXI4-Lite slave
  input  wire [5:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [5:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Per-phase readings, signed mW / mvar / mVA, one sample per strobe
  input  wire              sample_strobe,
  input  wire [NPH*PW-1:0] phase_act_mw,
  input  wire [NPH*PW-1:0] phase_rea_mw,
  input  wire [NPH*PW-1:0] phase_app_mw,
  input  wire [NPH*32-1:0] phase_volt_mv,
  // Front-end ready lines, per phase
  input  wire [NPH-1:0]    fe_rx_pin,
  input  wire [NPH-1:0]    fe_ready_pin,
  output wire [NPH-1:0]    sample_ready_flag,
  output wire              isolation_two_ch,
  // Outputs
  output reg  [NPH*PW-1:0] reported_act_mw,
  output reg               act_pulse_led,
  output reg               rea_pulse_led,
  output reg               app_pulse_led,
  output reg  [NPH-1:0]    phase_pulse_led,
  output reg               volt_interrupted,
  output reg               resync_req,
  output reg  [63:0]       total_act_mwms,
  output reg  [63:0]       total_rea_mwms,
  output wire              irq
);

  // ==========================================================
  // Registers and AXI4-Lite slave
  // ==========================================================
  reg [31:0] ctrl, pfloor, sfloor, int_thr;
  reg [15:0] pulses_kwh;
  reg [7:0]  dur;
  reg [`EPG_S_W-1:0] status, mask;
  reg [`EPG_S_W-1:0] events;
  reg [3:0]  aw_idx;
  reg        aw_held, w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  wire neutral = ctrl[`EPG_C_NEUTRAL];
  // Totals forced off under neutral monitoring
  wire tot_act_en = ctrl[`EPG_C_TOT_ACT] & ~neutral;
  wire tot_rea_en = ctrl[`EPG_C_TOT_REA] & ~neutral;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign irq = |(status & mask);

  wire wr_go = aw_held & w_held & ~s_axi_bvalid;

  // Byte-lane merge of a write into a 32-bit register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = s[k] ? d[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // Write channel capture and register update; set beats clear
  always @(posedge clk) begin
    if (sys_rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= 4'h0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl         <= `EPG_CTRL_RESET;
      pfloor       <= 32'h00000000;
      sfloor       <= 32'h00000000;
      int_thr      <= `EPG_INT_THR_DEFAULT;
      pulses_kwh   <= `EPG_PULSES_DEFAULT;
      dur          <= `EPG_DUR_DEFAULT;
      status       <= {`EPG_S_W{1'b0}};
      mask         <= {`EPG_S_W{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Set wins over a write-one clear in the same cycle
      status <= status | events;
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (aw_idx)
          `EPG_REG_CTRL:   ctrl    <= merge(ctrl, w_data, w_strb);
          `EPG_REG_PFLOOR: pfloor  <= merge(pfloor, w_data, w_strb);
          `EPG_REG_SFLOOR: sfloor  <= merge(sfloor, w_data, w_strb);
          `EPG_REG_INTTHR: int_thr <= merge(int_thr, w_data, w_strb);
          `EPG_REG_PULSES: begin
            if (w_strb[0]) pulses_kwh[7:0]  <= w_data[7:0];
            if (w_strb[1]) pulses_kwh[15:8] <= w_data[15:8];
          end
          `EPG_REG_DUR:    if (w_strb[0]) dur <= w_data[7:0];
          `EPG_REG_STATUS:
            if (w_strb[0])
              status <= (status & ~w_data[`EPG_S_W-1:0]) | events;
          `EPG_REG_MASK:   if (w_strb[0]) mask <= w_data[`EPG_S_W-1:0];
          default:         s_axi_bresp <= 2'h2;  // Unmapped: SLVERR
        endcase
      end
    end
  end

  // Read channel: one-cycle latency after address accept
  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr[5:2])
        `EPG_REG_CTRL:   s_axi_rdata <= ctrl;
        `EPG_REG_PFLOOR: s_axi_rdata <= pfloor;
        `EPG_REG_SFLOOR: s_axi_rdata <= sfloor;
        `EPG_REG_INTTHR: s_axi_rdata <= int_thr;
        `EPG_REG_PULSES: s_axi_rdata <= {16'h0000, pulses_kwh};
        `EPG_REG_DUR:    s_axi_rdata <= {24'h000000, dur};
        `EPG_REG_STATUS: s_axi_rdata <= {27'h0000000, volt_interrupted,
                                         status};
        `EPG_REG_MASK:   s_axi_rdata <= {28'h0000000, mask};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Isolation mode and ready lines
  // ==========================================================
  // The front ends must be strapped the same way; nothing here can detect
  // a mismatch, so the mode is exported for the board to check and also picks fe_rx_pin or fe_ready_pin as the ready input
  assign isolation_two_ch = ctrl[`EPG_C_TWO_CH];
  reg [NPH-1:0] rdy_s1, rdy_s2, rdy_s3;
  // Three flops, a change counts once stages two and three agree
  always @(posedge clk) begin
    if (sys_rst) begin
      rdy_s1            <= {NPH{1'b0}};
      rdy_s2            <= {NPH{1'b0}};
      rdy_s3            <= {NPH{1'b0}};
    end else begin
      rdy_s1 <= ctrl[`EPG_C_TWO_CH] ? fe_rx_pin : fe_ready_pin;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
    end
  end
  reg [NPH-1:0] rdy_q;
  always @(posedge clk) begin
    if (sys_rst)
      rdy_q <= {NPH{1'b0}};
    else
      rdy_q <= (rdy_s2 & rdy_s3) | (rdy_q & (rdy_s2 | rdy_s3));
  end
  assign sample_ready_flag = rdy_q;

  // ==========================================================
  // Per-phase floors, sums and energy
  // ==========================================================
  reg signed [PW+1:0] sum_act, sum_rea;
  reg [NPH-1:0]       ph_ok;
  reg [63:0]          ph_act_e [0:NPH-1];
  reg [63:0]          ph_rea_e [0:NPH-1];
  reg [63:0]          ph_app_e [0:NPH-1];

  function [PW-1:0] absv;
    input [PW-1:0] v;
    begin
      absv = v[PW-1] ? (~v + 1'b1) : v;
    end
  endfunction

  // Sum only phases at or above their floor
  integer i;
  always @* begin
    sum_act = {(PW+2){1'b0}};
    sum_rea = {(PW+2){1'b0}};
    ph_ok   = {NPH{1'b0}};
    for (i = 0; i < NPH; i = i + 1) begin
      ph_ok[i] = absv(phase_act_mw[i*PW +: PW]) >= pfloor[PW-1:0];
      if (ph_ok[i]) begin
        sum_act = sum_act + {{2{phase_act_mw[i*PW+PW-1]}},
                             phase_act_mw[i*PW +: PW]};
        sum_rea = sum_rea + {{2{phase_rea_mw[i*PW+PW-1]}},
                             phase_rea_mw[i*PW +: PW]};
      end
    end
  end

  // Per-phase buffers, one sample per strobe in mW*sample units
  genvar g;
  generate
    for (g = 0; g < NPH; g = g + 1) begin : g_ph
      always @(posedge clk) begin
        if (sys_rst) begin
          ph_act_e[g] <= 64'h0000000000000000;
          ph_rea_e[g] <= 64'h0000000000000000;
          ph_app_e[g] <= 64'h0000000000000000;
        end else if (sample_strobe && ph_ok[g]) begin
          if (ctrl[`EPG_C_PH_ACT])
            ph_act_e[g] <= ph_act_e[g] + {{(64-PW){1'b0}},
                                          absv(phase_act_mw[g*PW +: PW])};
          if (ctrl[`EPG_C_PH_REA])
            ph_rea_e[g] <= ph_rea_e[g] + {{(64-PW){1'b0}},
                                          absv(phase_rea_mw[g*PW +: PW])};
          if (ctrl[`EPG_C_PH_APP])
            ph_app_e[g] <= ph_app_e[g] + {{(64-PW){1'b0}},
                                          absv(phase_app_mw[g*PW +: PW])};
        end
      end
    end
  endgenerate

  // Reported power is registered unchanged on each strobe, never gated by the floors
  always @(posedge clk) begin
    if (sys_rst)
      reported_act_mw <= {(NPH*PW){1'b0}};
    else if (sample_strobe)
      reported_act_mw <= phase_act_mw;
  end

  // ==========================================================
  // Total energy, pulse quanta with remainder carry
  // ==========================================================
  // One pulse quantum in mW*sample units: 1 kWh / pulses_per_kwh
  wire [63:0] quantum = (`EPG_MWH_PER_KWH * `EPG_MS_PER_HOUR * 4)
                        / {48'h000000000000, pulses_kwh};
  wire [PW+1:0] mag_act = sum_act[PW+1] ? -sum_act : sum_act;
  wire [PW+1:0] mag_rea = sum_rea[PW+1] ? -sum_rea : sum_rea;
  wire act_gate = mag_act >= {2'b00, sfloor[PW-1:0]};
  reg [63:0] act_acc, rea_acc;
  reg        act_fire, rea_fire;

  always @(posedge clk) begin
    if (sys_rst) begin
      act_acc        <= 64'h0000000000000000;
      rea_acc        <= 64'h0000000000000000;
      total_act_mwms <= 64'h0000000000000000;
      total_rea_mwms <= 64'h0000000000000000;
      act_fire       <= 1'b0;
      rea_fire       <= 1'b0;
    end else begin
      act_fire <= 1'b0;
      rea_fire <= 1'b0;
      if (sample_strobe && act_gate) begin
        if (tot_act_en) begin
          total_act_mwms <= total_act_mwms + {{(62-PW){1'b0}}, mag_act};
          // Residue kept past a pulse, so no energy is lost
          if (act_acc + {{(62-PW){1'b0}}, mag_act} >= quantum) begin
            act_acc  <= act_acc + {{(62-PW){1'b0}}, mag_act} - quantum;
            act_fire <= 1'b1;
          end else
            act_acc <= act_acc + {{(62-PW){1'b0}}, mag_act};
        end
        if (tot_rea_en) begin
          total_rea_mwms <= total_rea_mwms + {{(62-PW){1'b0}}, mag_rea};
          if (rea_acc + {{(62-PW){1'b0}}, mag_rea} >= quantum) begin
            rea_acc  <= rea_acc + {{(62-PW){1'b0}}, mag_rea} - quantum;
            rea_fire <= 1'b1;
          end else
            rea_acc <= rea_acc + {{(62-PW){1'b0}}, mag_rea};
        end
      end
    end
  end

  // ==========================================================
  // 4 kHz tick and LED stretch
  // ==========================================================
  reg [31:0] tick_cnt;
  reg        tick;
  reg [8:0]  act_left, rea_left;

  always @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICKD - 1) begin
      tick_cnt <= 32'h00000000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick     <= 1'b0;
    end
  end

  // One spare count covers the partial first tick; a new pulse restarts it
  always @(posedge clk) begin
    if (sys_rst) begin
      act_left        <= 9'h000;
      rea_left        <= 9'h000;
      act_pulse_led   <= 1'b0;
      rea_pulse_led   <= 1'b0;
      app_pulse_led   <= 1'b0;
      phase_pulse_led <= {NPH{1'b0}};
    end else begin
      if (act_fire)
        act_left <= {1'b0, dur} + 9'h001;
      else if (tick && act_left != 9'h000)
        act_left <= act_left - 9'h001;
      if (rea_fire)
        rea_left <= {1'b0, dur} + 9'h001;
      else if (tick && rea_left != 9'h000)
        rea_left <= rea_left - 9'h001;
      act_pulse_led   <= act_fire | (act_left != 9'h000);
      rea_pulse_led   <= rea_fire | (rea_left != 9'h000);
      app_pulse_led   <= 1'b0;
      phase_pulse_led <= {NPH{1'b0}};
    end
  end

  // ==========================================================
  // Voltage interruption with hysteresis
  // ==========================================================
  reg [NPH-1:0] v_low, v_high;
  integer j;
  always @* begin
    v_low  = {NPH{1'b0}};
    v_high = {NPH{1'b0}};
    for (j = 0; j < NPH; j = j + 1) begin
      v_low[j]  = phase_volt_mv[j*32 +: 32] + `EPG_HYST_MV < int_thr;
      v_high[j] = phase_volt_mv[j*32 +: 32] > int_thr + `EPG_HYST_MV;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      volt_interrupted <= 1'b0;
      resync_req       <= 1'b0;
    end else begin
      resync_req <= 1'b0;
      if (sample_strobe) begin
        if (!volt_interrupted && |v_low)
          volt_interrupted <= 1'b1;
        else if (volt_interrupted && &v_high) begin
          volt_interrupted <= 1'b0;
          resync_req       <= 1'b1;
        end
      end
    end
  end

  // Interrupt events
  always @* begin
    events = {`EPG_S_W{1'b0}};
    events[`EPG_S_ACT_PULSE] = act_fire;
    events[`EPG_S_REA_PULSE] = rea_fire;
    events[`EPG_S_INT_ENTER] = sample_strobe & ~volt_interrupted & |v_low;
    events[`EPG_S_INT_LEAVE] = resync_req;
  end

endmodule
`default_nettype wire

// >>> test/epg_monitor.sv
// Checker bound to the energy pulse generator ports
`timescale 1ns/100ps
`default_nettype none
module epg_monitor #(
  parameter NPH   = 3,
  parameter PW    = 32,
  parameter TICKD = 25000
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              sample_strobe,
  input wire logic [NPH*PW-1:0] phase_act_mw,
  input wire logic [NPH*PW-1:0] reported_act_mw,
  input wire logic              act_pulse_led,
  input wire logic              rea_pulse_led,
  input wire logic              app_pulse_led,
  input wire logic [NPH-1:0]    phase_pulse_led,
  input wire logic              volt_interrupted,
  input wire logic              resync_req,
  input wire logic [63:0]       total_act_mwms,
  input wire logic [63:0]       total_rea_mwms
);
  localparam int LMAX = 257 * TICKD;
  logic [31:0] led_run;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Helper: cycles the active LED has stayed on
  // A duration counter that never empties shows up here as a run reaching LMAX
  always @(posedge clk) begin
    if (sys_rst || !act_pulse_led) begin
      led_run <= 32'h00000000;
    end else begin
      led_run <= led_run + 32'h00000001;
    end
  end
  // ==========================================================
  // Assertions
  AST_NO_EXTRA:
    assert property (!app_pulse_led && phase_pulse_led == '0)
    else $error("apparent or phase pulse output active");
  AST_REPORT:
    assert property (sample_strobe |=> reported_act_mw == $past(phase_act_mw))
    else $error("reported power differs from sampled power");
  AST_TOTAL_HOLD:
    assert property (!sample_strobe && !$past(sample_strobe)
                     |=> $stable(total_act_mwms))
    else $error("total energy moved without a sample");
  AST_ACT_CAUSE:
    assert property ($rose(act_pulse_led)
                     |-> total_act_mwms != $past(total_act_mwms, 3))
    else $error("active pulse without energy growth");
  AST_REA_CAUSE:
    assert property ($rose(rea_pulse_led)
                     |-> total_rea_mwms != $past(total_rea_mwms, 3))
    else $error("reactive pulse without energy growth");
  AST_LED_MIN:
    assert property ($rose(act_pulse_led) |-> act_pulse_led [*8])
    else $error("active pulse too short");
  AST_LED_MAX:
    assert property (act_pulse_led |-> led_run < LMAX)
    else $error("active pulse longer than the longest duration");
  AST_INT_CAUSE:
    assert property ($changed(volt_interrupted)
                     |-> $past(sample_strobe) || $past(sample_strobe, 2))
    else $error("interruption state changed without a sample");
  AST_RESYNC_AFTER:
    assert property ($fell(volt_interrupted) |-> ##[0:2] resync_req)
    else $error("no resync after interruption ended");
  AST_RESYNC_ONE:
    assert property (resync_req |=> !resync_req && !volt_interrupted)
    else $error("resync request not a single pulse");
endmodule
bind epg_top epg_monitor #(.NPH(NPH), .PW(PW), .TICKD(TICKD)) epg_monitor_i (
  .clk, .sys_rst, .sample_strobe, .phase_act_mw, .reported_act_mw,
  .act_pulse_led, .rea_pulse_led, .app_pulse_led, .phase_pulse_led,
  .volt_interrupted, .resync_req, .total_act_mwms, .total_rea_mwms
);
`default_nettype wire

// >>> test/epg_ref_meter.sv
// Reference meter model that counts the total energy pulses and times the active ones
`timescale 1ns/100ps
`default_nettype none
module epg_ref_meter (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        act_led,
  input  wire logic        rea_led,
  output var  logic [7:0]  act_cnt,
  output var  logic [7:0]  rea_cnt,
  output var  logic [15:0] act_width
);
  logic        act_d;
  logic        rea_d;
  logic [15:0] run;
  // ==========================================================
  // Edge counting: a real meter sees LED edges only, so a stuck LED counts once
  always @(posedge clk) begin
    if (rst) begin
      act_d <= 1'b0;
      rea_d <= 1'b0;
      act_cnt <= 8'h00;
      rea_cnt <= 8'h00;
      run <= 16'h0000;
      act_width <= 16'h0000;
    end else begin
      act_d <= act_led;
      rea_d <= rea_led;
      run <= act_led ? run + 16'h0001 : 16'h0000;
      if (act_led && !act_d) begin
        act_cnt <= act_cnt + 8'h01;
      end
      if (rea_led && !rea_d) begin
        rea_cnt <= rea_cnt + 8'h01;
      end
      if (!act_led && act_d) begin
        act_width <= run;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the energy pulse generator
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [31:0] Q3 = 32'h2CB41780;
  localparam logic [31:0] QH = 32'h165A0BC0;
  localparam logic [31:0] VN = 32'h00038270;
  logic        clk, sys_rst, sample_strobe, irq, isolation_two_ch;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, volt_interrupted, resync_req;
  logic        act_pulse_led, rea_pulse_led, app_pulse_led;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [2:0]  fe_rx_pin, fe_ready_pin, sample_ready_flag, phase_pulse_led;
  logic [95:0] phase_act_mw, phase_rea_mw, phase_app_mw, phase_volt_mv;
  logic [95:0] reported_act_mw;
  logic [63:0] total_act_mwms, total_rea_mwms, tot;
  logic [7:0]  act_cnt, rea_cnt, rs_cnt;
  logic [15:0] act_width;
  integer      error_cnt, checks_done, cyc;
  epg_top #(.TICKD(10)) epg_top_i (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sample_strobe, .phase_act_mw, .phase_rea_mw, .phase_app_mw,
    .phase_volt_mv, .fe_rx_pin, .fe_ready_pin, .sample_ready_flag,
    .isolation_two_ch, .reported_act_mw, .act_pulse_led, .rea_pulse_led,
    .app_pulse_led, .phase_pulse_led, .volt_interrupted, .resync_req,
    .total_act_mwms, .total_rea_mwms, .irq
  );
  epg_ref_meter epg_ref_meter_i (
    .clk, .rst(sys_rst), .act_led(act_pulse_led), .rea_led(rea_pulse_led),
    .act_cnt, .rea_cnt, .act_width
  );
  // ==========================================================
  // Clock, resync pulse count and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rs_cnt <= sys_rst ? 8'h00 : rs_cnt + {7'h00, resync_req};
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  // ==========================================================
  // Comparison and closing
  task chk(input logic [63:0] got, input logic [63:0] exp_v);
    begin
      checks_done = checks_done + 1;
      if (got !== exp_v) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp_v);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // ==========================================================
  // Register bus master: address and data offered together
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    begin
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
    end
  endtask
  task rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
    end
  endtask
  // One set of phase readings; reactive and apparent mirror the active ones
  task smp(input logic [31:0] a, b, c, v);
    begin
      @(posedge clk);
      phase_act_mw <= {c, b, a};
      phase_rea_mw <= {c, b, a};
      phase_app_mw <= {c, b, a};
      phase_volt_mv <= {v, v, v};
      sample_strobe <= 1'b1;
      @(posedge clk);
      sample_strobe <= 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, sample_strobe} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hF;
    {phase_act_mw, phase_rea_mw, phase_app_mw} = 288'h0;
    phase_volt_mv = {3{VN}};
    {fe_rx_pin, fe_ready_pin} = 6'h00;
    {error_cnt, checks_done, cyc} = 96'h0;
    tot = 64'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(6'h00, 32'h0000003F, 2'h0);
    rd(6'h10, 32'h00001900, 2'h0);
    rd(6'h14, 32'h00000014, 2'h0);
    rd(6'h0C, 32'h00030D40, 2'h0);
    rd(6'h1C, 32'h00000000, 2'h0);
    rd(6'h20, 32'h00000000, 2'h2);
    wr(6'h24, 32'h00000001, 2'h2);
    wr(6'h14, 32'h000000FF, 2'h0);
    rd(6'h14, 32'h000000FF, 2'h0);
    $display("test registers done");
    wr(6'h14, 32'h00000002, 2'h0);
    wr(6'h1C, 32'h00000003, 2'h0);
    smp(Q3, Q3, Q3, VN);
    tot = tot + 64'h00000000861C4680;
    chk(total_rea_mwms, tot);
    chk(total_act_mwms, tot);
    chk(act_cnt, 64'h1);
    chk(rea_cnt, 64'h1);
    chk(act_width >= 16'd20 && act_width <= 16'd30, 64'h1);
    chk(irq, 64'h1);
    rd(6'h18, 32'h00000003, 2'h0);
    wr(6'h1C, 32'h00000000, 2'h0);
    chk(irq, 64'h0);
    wr(6'h1C, 32'h00000003, 2'h0);
    wr(6'h18, 32'h00000003, 2'h0);
    chk(irq, 64'h0);
    rd(6'h18, 32'h00000000, 2'h0);
    smp(QH, QH, QH, VN);
    chk(act_cnt, 64'h1);
    smp(QH, QH, QH, VN);
    chk(act_cnt, 64'h2);
    wr(6'h10, 32'h00003200, 2'h0);
    smp(QH, QH, QH, VN);
    tot = tot + 64'h00000000C92A69C0;
    chk(act_cnt, 64'h3);
    chk(total_act_mwms, tot);
    wr(6'h10, 32'h00001900, 2'h0);
    $display("test pulses done");
    wr(6'h04, 32'h00000064, 2'h0);
    smp(Q3, Q3, 32'h00000032, VN);
    tot = tot + 64'h0000000059682F00;
    chk(reported_act_mw[95:64], 64'h32);
    chk(total_act_mwms, tot);
    chk(act_cnt, 64'h3);
    wr(6'h08, 32'h77359400, 2'h0);
    smp(32'h23C34600, 32'h23C34600, 32'h23C34600, VN);
    chk(total_act_mwms, tot);
    chk(act_cnt, 64'h3);
    wr(6'h08, 32'h00000000, 2'h0);
    wr(6'h00, 32'h0000007F, 2'h0);
    smp(Q3, Q3, Q3, VN);
    chk(total_act_mwms, tot);
    wr(6'h00, 32'h0000003F, 2'h0);
    $display("test floors done");
    smp(32'h0, 32'h0, 32'h0, 32'h00030958);
    chk(volt_interrupted, 64'h0);
    smp(32'h0, 32'h0, 32'h0, 32'h00030957);
    chk(volt_interrupted, 64'h1);
    smp(32'h0, 32'h0, 32'h0, 32'h00031128);
    chk(volt_interrupted, 64'h1);
    chk(rs_cnt, 64'h0);
    smp(32'h0, 32'h0, 32'h0, 32'h00031129);
    chk(volt_interrupted, 64'h0);
    chk(rs_cnt, 64'h1);
    $display("test interruption done");
    fe_ready_pin <= 3'h5;
    fe_rx_pin <= 3'h2;
    repeat (6) @(posedge clk);
    chk(sample_ready_flag, 64'h5);
    wr(6'h00, 32'h000000BF, 2'h0);
    repeat (6) @(posedge clk);
    chk(sample_ready_flag, 64'h2);
    chk(isolation_two_ch, 64'h1);
    $display("test isolation done");
    report_and_stop;
  end
endmodule
`default_nettype wire
